// ### common/board_ctrl_pkg.sv
// shared constants and types for the board control and status register block
package board_ctrl_pkg;

  // bus command codes, one per access direction; the revision has a read code only
  localparam logic [7:0] CMD_CTRL_WR   = 8'hA0;
  localparam logic [7:0] CMD_CTRL_RD   = 8'hA1;
  localparam logic [7:0] CMD_STAT_A_WR = 8'hB0;
  localparam logic [7:0] CMD_STAT_A_RD = 8'hB1;
  localparam logic [7:0] CMD_STAT_B_WR = 8'hB2;
  localparam logic [7:0] CMD_STAT_B_RD = 8'hB3;
  localparam logic [7:0] CMD_REV_RD    = 8'hC1;

  // seven-bit two-wire bus address of this block
  localparam logic [6:0] BUS_DEV_ADDR  = 7'h2E;

  // reset values and the answer to an unmapped or write-only read
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] READ_NONE     = 8'h00;
  localparam logic [7:0] REV_DEFAULT   = 8'h01;   // arbitrary value

  // board_control fields
  localparam int CTRL_SOFT_RESET_BIT   = 0;
  localparam int CTRL_RETRIG_BIT       = 2;
  localparam int CTRL_PERIOD_LSB       = 3;
  localparam int CTRL_PERIOD_MSB       = 4;

  // reset_cause_status_a fields
  localparam int STA_1V8_BIT           = 7;
  localparam int STA_1V35_BIT          = 4;

  // watchdog_reset_cause_status_b fields
  localparam int STB_ARMED_BIT         = 7;
  localparam int STB_WDOG_RST_BIT      = 6;
  localparam int STB_HALF_BIT          = 5;
  localparam int STB_12V_BIT           = 4;
  localparam int STB_5V_BIT            = 3;
  localparam int STB_3V3_BIT           = 0;

  // timing
  localparam longint unsigned CLK_HZ        = 250_000_000;
  localparam longint unsigned WDOG_TIME_S_0 = 2;
  localparam longint unsigned WDOG_TIME_S_1 = 10;
  localparam longint unsigned WDOG_TIME_S_2 = 50;
  localparam longint unsigned WDOG_TIME_S_3 = 250;
  localparam int WDOG_CNT_W                 = 36;
  localparam logic [WDOG_CNT_W-1:0] WDOG_CYCLES_0 = WDOG_CNT_W'(WDOG_TIME_S_0 * CLK_HZ);
  localparam logic [WDOG_CNT_W-1:0] WDOG_CYCLES_1 = WDOG_CNT_W'(WDOG_TIME_S_1 * CLK_HZ);
  localparam logic [WDOG_CNT_W-1:0] WDOG_CYCLES_2 = WDOG_CNT_W'(WDOG_TIME_S_2 * CLK_HZ);
  localparam logic [WDOG_CNT_W-1:0] WDOG_CYCLES_3 = WDOG_CNT_W'(WDOG_TIME_S_3 * CLK_HZ);
  localparam longint unsigned SYS_RESET_NS  = 1000;
  localparam logic [7:0] SYS_RESET_CYCLES   = 8'((SYS_RESET_NS * CLK_HZ) / 1_000_000_000);

  // bus byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // phases of the two-wire byte-data slave
  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_CMD, BUS_CMD_ACK,
    BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RDATA_ACK
  } bus_phase_t;

endpackage

// ### rtl/board_control_status_regs.sv
// board control and status registers behind a two-wire byte-data slave
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - control bit 0 high performs system reset
// - status A read 0xB1, cleared 0xB0
// - status B read 0xB3, cleared 0xB2
// - status A bit 7: 1.8 V failure
// - status A bit 4: 1.35 V failure
// - reserved status bits always read zero
// - status A flags survive system reset
// - any write to status clears it
// - status B bit 7: watchdog armed, live
// - status B bit 6: watchdog reset cause
// - status B bit 5: half period used
// - status B bit 4: 12 V rail absent
// - status B bit 3: 5 V failure
// - status B bit 0: 3.3 V failure
// - status B sticky except armed and half
// - revision readable at 0xC1, never written
// - control written 0xA0, read 0xA1, reset 0x00
// - period select gives 2/10/50/250 seconds
// - retrigger edge restarts; first edge arms watchdog
module board_control_status_regs
#(
  parameter logic [board_ctrl_pkg::WDOG_CNT_W-1:0] WDOG_LIMIT_0 = board_ctrl_pkg::WDOG_CYCLES_0,
  parameter logic [board_ctrl_pkg::WDOG_CNT_W-1:0] WDOG_LIMIT_1 = board_ctrl_pkg::WDOG_CYCLES_1,
  parameter logic [board_ctrl_pkg::WDOG_CNT_W-1:0] WDOG_LIMIT_2 = board_ctrl_pkg::WDOG_CYCLES_2,
  parameter logic [board_ctrl_pkg::WDOG_CNT_W-1:0] WDOG_LIMIT_3 = board_ctrl_pkg::WDOG_CYCLES_3,
  parameter logic [7:0]                            REVISION_NUMBER = board_ctrl_pkg::REV_DEFAULT
)
(
  input  wire logic core_clk,         // 250 MHz block clock
  input  wire logic rst_b,            // power-on reset, active low
  input  wire logic scl_in,           // bus clock level
  input  wire logic sda_in,           // bus data level
  output logic      sda_out,          // bus data drive value
  output logic      sda_oe,           // bus data pulled low while high
  input  wire logic fail_1v8,         // 1.8 V regulator fault
  input  wire logic fail_1v35,        // 1.35 V regulator fault
  input  wire logic fail_5v,          // 5 V regulator fault
  input  wire logic fail_3v3,         // 3.3 V regulator fault
  input  wire logic rail_12v_absent,  // 12 V auxiliary rail missing
  output logic      system_reset      // system reset request, active high
);
  import board_ctrl_pkg::*;

  typedef struct packed {
    bus_phase_t  phase;     // slave phase
    logic        scl_q;     // previous bus clock
    logic        sda_q;     // previous bus data
    logic [7:0]  shift;     // byte shifter
    logic [3:0]  bit_cnt;   // bits of the current byte
    logic        rw;        // read direction
    logic [7:0]  cmd;       // command code of the transaction
    logic        sda_oe;    // pull data low
    logic [7:0]  ctrl;      // board_control
    logic        sys_rst;   // system reset active
    logic [7:0]  rst_cnt;   // cycles of reset left
  } main_state_t;

  main_state_t s;           // registered state
  main_state_t next_s;      // next state

  logic       scl_rise;     // bus clock rising
  logic       scl_fall;     // bus clock falling
  logic       bus_start;    // start or repeated start
  logic       bus_stop;     // stop
  logic       wr_now;       // data byte written this cycle
  logic [7:0] rd_word;      // value for the current read command
  logic       clr_a;        // clear status A
  logic       clr_b;        // clear status B
  logic       wdog_armed;   // live armed state
  logic       wdog_half;    // half period used
  logic       wdog_expire;  // time-out pulse
  logic [5:0] flag_set;     // sticky flag events
  logic [5:0] flag_clr;     // sticky flag clears
  logic [5:0] flag_q;       // sticky flag values

  // bus condition detection, inputs are synchronous to core_clk
  always_comb
  begin
    scl_rise  = scl_in & ~s.scl_q;
    scl_fall  = ~scl_in & s.scl_q;
    bus_start = scl_in & s.scl_q & s.sda_q & ~sda_in;
    bus_stop  = scl_in & s.scl_q & ~s.sda_q & sda_in;
  end

  // read decode; unmapped and write-only codes answer zero
  always_comb
  begin
    rd_word = READ_NONE;
    case (s.cmd)
      CMD_CTRL_RD:
        rd_word = s.ctrl;
      CMD_STAT_A_RD:
      begin
        rd_word[STA_1V8_BIT]  = flag_q[0];
        rd_word[STA_1V35_BIT] = flag_q[1];
      end
      CMD_STAT_B_RD:
      begin
        rd_word[STB_ARMED_BIT]    = wdog_armed;
        rd_word[STB_WDOG_RST_BIT] = flag_q[2];
        rd_word[STB_HALF_BIT]     = wdog_half;
        rd_word[STB_12V_BIT]      = flag_q[3];
        rd_word[STB_5V_BIT]       = flag_q[4];
        rd_word[STB_3V3_BIT]      = flag_q[5];
      end
      CMD_REV_RD:
        rd_word = REVISION_NUMBER;
      default:
        rd_word = READ_NONE;
    endcase
  end

  // byte-data slave, control register and system reset sequencer
  always_comb
  begin
    next_s       = s;
    next_s.scl_q = scl_in;
    next_s.sda_q = sda_in;
    wr_now       = 1'b0;
    if (bus_start)
    begin
      // repeated start keeps the command for a following read
      next_s.phase   = BUS_ADDR;
      next_s.bit_cnt = '0;
      next_s.sda_oe  = 1'b0;
    end
    else if (bus_stop)
    begin
      next_s.phase  = BUS_IDLE;
      next_s.sda_oe = 1'b0;
    end
    else
    begin
      case (s.phase)
        BUS_ADDR, BUS_CMD, BUS_WDATA:
        begin
          if (scl_rise)
          begin
            // sample on the rising bus clock
            next_s.shift   = {s.shift[6:0], sda_in};
            next_s.bit_cnt = s.bit_cnt + 1'b1;
          end
          else if (scl_fall && s.bit_cnt == BITS_PER_BYTE)
          begin
            // whole byte in: acknowledge on the next low phase
            next_s.bit_cnt = '0;
            next_s.sda_oe  = 1'b1;
            if (s.phase == BUS_ADDR)
            begin
              if (s.shift[7:1] == BUS_DEV_ADDR)
              begin
                next_s.rw    = s.shift[0];
                next_s.phase = BUS_ADDR_ACK;
              end
              else
              begin
                // not ours: stay off the bus until the next start
                next_s.sda_oe = 1'b0;
                next_s.phase  = BUS_IDLE;
              end
            end
            else if (s.phase == BUS_CMD)
            begin
              next_s.cmd   = s.shift;
              next_s.phase = BUS_CMD_ACK;
            end
            else
            begin
              wr_now       = 1'b1;
              next_s.phase = BUS_WDATA_ACK;
            end
          end
        end
        BUS_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (s.rw)
            begin
              // load the answer and drive its top bit
              next_s.shift  = rd_word;
              next_s.sda_oe = ~rd_word[7];
              next_s.phase  = BUS_RDATA;
            end
            else
            begin
              next_s.sda_oe = 1'b0;
              next_s.phase  = BUS_CMD;
            end
          end
        end
        BUS_CMD_ACK:
        begin
          if (scl_fall)
          begin
            next_s.sda_oe = 1'b0;
            next_s.phase  = BUS_WDATA;
          end
        end
        BUS_WDATA_ACK:
        begin
          // one data byte per transaction, further bytes go unanswered
          if (scl_fall)
          begin
            next_s.sda_oe = 1'b0;
            next_s.phase  = BUS_IDLE;
          end
        end
        BUS_RDATA:
        begin
          if (scl_fall)
          begin
            next_s.bit_cnt = s.bit_cnt + 1'b1;
            if (s.bit_cnt == BITS_PER_BYTE - 1'b1)
            begin
              // release for the master's acknowledge
              next_s.sda_oe = 1'b0;
              next_s.phase  = BUS_RDATA_ACK;
            end
            else
            begin
              next_s.shift  = {s.shift[6:0], 1'b0};
              next_s.sda_oe = ~s.shift[6];
            end
          end
        end
        BUS_RDATA_ACK:
        begin
          if (scl_fall)
            next_s.phase = BUS_IDLE;
        end
        default:
          next_s.phase = BUS_IDLE;
      endcase
    end

    // control register write; ignored while a system reset runs
    if (wr_now && s.cmd == CMD_CTRL_WR && !s.sys_rst)
      next_s.ctrl = s.shift;

    // system reset sequencer
    if (s.sys_rst)
    begin
      // control returns to its default for the whole pulse
      next_s.ctrl = CTRL_RESET;
      if (s.rst_cnt == '0)
        next_s.sys_rst = 1'b0;
      else
        next_s.rst_cnt = s.rst_cnt - 1'b1;
    end
    else if (s.ctrl[CTRL_SOFT_RESET_BIT] || wdog_expire)
    begin
      next_s.sys_rst = 1'b1;
      next_s.rst_cnt = SYS_RESET_CYCLES - 1'b1;
      next_s.ctrl    = CTRL_RESET;
    end
  end

  // state register, power-on reset only
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s       <= '0;
      s.phase <= BUS_IDLE;
      s.ctrl  <= CTRL_RESET;
      s.scl_q <= 1'b1;        // idle bus level, so no false edge follows reset
      s.sda_q <= 1'b1;        // idle bus level, so no false start or stop
    end
    else
      s <= next_s;
  end

  // any data byte written to a status code clears it, value ignored
  always_comb
  begin
    clr_a = wr_now && s.cmd == CMD_STAT_A_WR;
    clr_b = wr_now && s.cmd == CMD_STAT_B_WR;
    // faults latch at once, well before the reset pulse ends
    flag_set = {fail_3v3, fail_5v, rail_12v_absent,
                wdog_expire, fail_1v35, fail_1v8};
    flag_clr = {clr_b, clr_b, clr_b, clr_b, clr_a, clr_a};
  end

  // sticky flags see only rst_b, so a system reset leaves them alone
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_flag
      sticky_flag u_flag
      (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .set      (flag_set[gi]),
        .clr      (flag_clr[gi]),
        .flag     (flag_q[gi])
      );
    end
  endgenerate

  // watchdog, held inactive through each system reset
  wdog_timer
  #(
    .LIMIT_0 (WDOG_LIMIT_0),
    .LIMIT_1 (WDOG_LIMIT_1),
    .LIMIT_2 (WDOG_LIMIT_2),
    .LIMIT_3 (WDOG_LIMIT_3)
  )
  u_wdog
  (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .sys_rst    (s.sys_rst),
    .period_sel (s.ctrl[CTRL_PERIOD_MSB:CTRL_PERIOD_LSB]),
    .retrig     (s.ctrl[CTRL_RETRIG_BIT]),
    .armed      (wdog_armed),
    .half       (wdog_half),
    .expire     (wdog_expire)
  );

  // pin drive: open drain, value always low
  assign sda_out      = 1'b0;
  assign sda_oe       = s.sda_oe;
  assign system_reset = s.sys_rst;
endmodule
`default_nettype wire

// ### rtl/sticky_flag.sv
// one sticky status flag kept by the power-on reset only
`timescale 1ns/1ps
`default_nettype none
module sticky_flag
(
  input  wire logic core_clk,   // block clock
  input  wire logic rst_b,      // power-on reset, not system reset
  input  wire logic set,        // hardware event
  input  wire logic clr,        // software clear
  output logic      flag        // sticky state
);
  import board_ctrl_pkg::*;

  typedef struct packed {
    logic flag;                 // held value
  } flag_state_t;

  flag_state_t s;               // registered state
  flag_state_t next_s;          // next state

  // set beats clear so an event in the clearing cycle survives
  always_comb
  begin
    next_s      = s;
    next_s.flag = set | (s.flag & ~clr);
  end

  // system reset does not reach here, only power-on
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign flag = s.flag;
endmodule
`default_nettype wire

// ### rtl/wdog_timer.sv
// watchdog timer with selectable period, half-time mark and expiry pulse
`timescale 1ns/1ps
`default_nettype none
module wdog_timer
#(
  parameter logic [board_ctrl_pkg::WDOG_CNT_W-1:0] LIMIT_0 = board_ctrl_pkg::WDOG_CYCLES_0,
  parameter logic [board_ctrl_pkg::WDOG_CNT_W-1:0] LIMIT_1 = board_ctrl_pkg::WDOG_CYCLES_1,
  parameter logic [board_ctrl_pkg::WDOG_CNT_W-1:0] LIMIT_2 = board_ctrl_pkg::WDOG_CYCLES_2,
  parameter logic [board_ctrl_pkg::WDOG_CNT_W-1:0] LIMIT_3 = board_ctrl_pkg::WDOG_CYCLES_3
)
(
  input  wire logic       core_clk,     // block clock
  input  wire logic       rst_b,        // power-on reset
  input  wire logic       sys_rst,      // system reset in progress
  input  wire logic [1:0] period_sel,   // wdog_period_select
  input  wire logic       retrig,       // wdog_retrigger_bit
  output logic            armed,        // live armed state
  output logic            half,         // half period used
  output logic            expire        // one-cycle time-out pulse
);
  import board_ctrl_pkg::*;

  typedef struct packed {
    logic                  armed;   // counting
    logic                  trg_q;   // last retrigger level
    logic                  half;    // half mark passed
    logic                  expire;  // time-out pulse
    logic [WDOG_CNT_W-1:0] cnt;     // cycles since retrigger
  } wdog_state_t;

  wdog_state_t s;                   // registered state
  wdog_state_t next_s;              // next state
  logic [WDOG_CNT_W-1:0] limit;     // selected period in cycles

  // period choice and count progress
  always_comb
  begin
    case (period_sel)
      2'h0:    limit = LIMIT_0;
      2'h1:    limit = LIMIT_1;
      2'h2:    limit = LIMIT_2;
      default: limit = LIMIT_3;
    endcase
    next_s        = s;
    next_s.expire = 1'b0;
    next_s.trg_q  = retrig;
    if (sys_rst)
    begin
      // inactive after system reset; control bits are cleared alongside
      next_s.armed = 1'b0;
      next_s.half  = 1'b0;
      next_s.cnt   = '0;
      next_s.trg_q = 1'b0;
    end
    else if (retrig != s.trg_q)
    begin
      // any edge arms and restarts
      next_s.armed = 1'b1;
      next_s.half  = 1'b0;
      next_s.cnt   = '0;
    end
    else if (s.armed)
    begin
      if (s.cnt == limit - 1'b1)
      begin
        next_s.expire = 1'b1;
        next_s.armed  = 1'b0;
        next_s.half   = 1'b0;
        next_s.cnt    = '0;
      end
      else
      begin
        next_s.cnt  = s.cnt + 1'b1;
        next_s.half = (s.cnt + 1'b1) >= (limit >> 1);
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign armed  = s.armed;
  assign half   = s.half;
  assign expire = s.expire;
endmodule
`default_nettype wire

// ### test/board_ctrl_checker_assertions.sv
// port-level assertions for the board control and status register block
`timescale 1ns/1ps
`default_nettype none
module board_ctrl_checker
(
  input wire logic core_clk,      // block clock
  input wire logic rst_b,         // power-on reset, active low
  input wire logic scl_in,        // bus clock level
  input wire logic sda_out,       // data drive value
  input wire logic sda_oe,        // data pulled low while high
  input wire logic system_reset   // system reset request
);
  import board_ctrl_pkg::*;
  logic [8:0] hi_cnt;             // cycles system reset has stood high
  logic [7:0] oe_cnt;             // cycles the block has held data low

  // run-length counters; a stuck output shows up as a count past its bound
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hi_cnt <= 9'h000;
      oe_cnt <= 8'h00;
    end
    else
    begin
      hi_cnt <= system_reset ? hi_cnt + 9'h001 : 9'h000;
      oe_cnt <= (sda_oe && oe_cnt != 8'hFF) ? oe_cnt + 8'h01 : (sda_oe ? oe_cnt : 8'h00);
    end
  end

  data_low_only_a : assert property (
    @(posedge core_clk) disable iff (!rst_b) sda_out == 1'b0)
    else $error("data line driven high");
  reset_quiet_a : assert property (
    @(posedge core_clk) disable iff (!rst_b) $rose(rst_b) |-> !system_reset && !sda_oe)
    else $error("outputs active right after reset");
  oe_low_phase_a : assert property (
    @(posedge core_clk) disable iff (!rst_b) $changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data drive changed outside clock low phase");
  oe_steady_high_a : assert property (
    @(posedge core_clk) disable iff (!rst_b) scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data drive changed while clock high");
  oe_bounded_a : assert property (
    @(posedge core_clk) disable iff (!rst_b) oe_cnt < 8'hC8)
    else $error("data line held low too long");
  soft_system_reset_length_a : assert property (
    @(posedge core_clk) disable iff (!rst_b) $fell(system_reset) |-> hi_cnt == 9'(SYS_RESET_CYCLES))
    else $error("system reset pulse length wrong");
  soft_system_reset_cap_a : assert property (
    @(posedge core_clk) disable iff (!rst_b) hi_cnt <= 9'(SYS_RESET_CYCLES))
    else $error("system reset stands too long");
  soft_system_reset_gap_a : assert property (
    @(posedge core_clk) disable iff (!rst_b) $fell(system_reset) |=> !system_reset [*8])
    else $error("system reset repeated without cause");
endmodule

bind board_control_status_regs board_ctrl_checker checker_i (
  .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .system_reset(system_reset));
`default_nettype wire

// ### test/smbus_host_model.sv
// two-wire bus master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model
(
  input  wire logic core_clk,   // paces every bus change
  input  wire logic sda_line,   // resolved data wire, pulled up
  output logic      scl,        // bus clock, idle high
  output logic      sda_drv     // 0 pulls data low, 1 releases
);
  import board_ctrl_pkg::*;
  initial scl = 1'b1;
  initial sda_drv = 1'b1;

  // whole cycles only, so every change lands by nba on a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one bit slot; data moves mid low phase, line read at end of high phase
  task automatic slot(input logic b, output logic r);
    tick(2);
    sda_drv <= b;
    tick(3);
    scl <= 1'b1;
    tick(4);
    r = sda_line;
    scl <= 1'b0;
  endtask
  // start from idle, or repeated start from a low clock
  task automatic start(input logic again);
    if (again)
    begin
      tick(2);
      sda_drv <= 1'b1;
      tick(3);
      scl <= 1'b1;
    end
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_drv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask
  // msb first, then the ninth slot carries the slave's acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) slot(d[i], r);
    slot(1'b1, r);
    ack = ~r;
  endtask
  // single byte-data transactions only, no block or word forms
  task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data, output logic ok);
    logic a;
    start(1'b0);
    send({BUS_DEV_ADDR, 1'b0}, ok);
    send(cmd, a);
    send(data, a);
    stop();
  endtask
  // the master ends the read with a not-acknowledge before stop
  task automatic read_reg(input logic [7:0] cmd, output logic [7:0] data, output logic ok);
    logic a;
    logic r;
    start(1'b0);
    send({BUS_DEV_ADDR, 1'b0}, ok);
    send(cmd, a);
    start(1'b1);
    send({BUS_DEV_ADDR, 1'b1}, a);
    ok = ok & a;
    for (int i = 7; i >= 0; i--) slot(1'b1, data[i]);
    slot(1'b1, r);
    stop();
  endtask
endmodule
`default_nettype wire

// ### test/test_board_control_status_regs.sv
// self-checking bench for the board control and status register block
`timescale 1ns/1ps
`default_nettype none
module test_board_control_status_regs;
  import board_ctrl_pkg::*;
  localparam int LIM0 = 3000;            // shortened watchdog periods
  localparam int LIM1 = 5000;
  localparam int LIM2 = 7000;
  localparam int LIM3 = 9000;
  localparam logic [7:0] REV = 8'h3C;    // arbitrary revision value
  // write code, write data, read code, expected read
  localparam logic [31:0] ROWS [7] = '{
    {CMD_CTRL_WR, 8'hF8, CMD_CTRL_RD, 8'hF8}, {CMD_CTRL_WR, 8'h02, CMD_CTRL_RD, 8'h02},
    {CMD_REV_RD, 8'h5A, CMD_REV_RD, REV}, {CMD_STAT_A_RD, 8'hFF, CMD_STAT_A_RD, 8'h00},
    {CMD_STAT_B_RD, 8'hFF, CMD_STAT_B_RD, 8'h00}, {8'h55, 8'hFF, 8'h55, READ_NONE},
    {CMD_CTRL_WR, 8'h00, CMD_CTRL_WR, READ_NONE}};
  int   lim [4] = '{LIM0, LIM1, LIM2, LIM3};
  logic core_clk, rst_b, scl, host_sda, sda_out, sda_oe, system_reset;
  logic fail_1v8, fail_1v35, fail_5v, fail_3v3, rail_12v_absent;
  int   cyc = 0, t0, n_fail, n_compared;
  wire  sda_line = host_sda & ~sda_oe;   // open drain with pull-up

  board_control_status_regs #(.WDOG_LIMIT_0(WDOG_CNT_W'(LIM0)), .WDOG_LIMIT_1(WDOG_CNT_W'(LIM1)),
    .WDOG_LIMIT_2(WDOG_CNT_W'(LIM2)), .WDOG_LIMIT_3(WDOG_CNT_W'(LIM3)), .REVISION_NUMBER(REV))
  DUT (.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .fail_1v8(fail_1v8), .fail_1v35(fail_1v35), .fail_5v(fail_5v),
    .fail_3v3(fail_3v3), .rail_12v_absent(rail_12v_absent), .system_reset(system_reset));
  smbus_host_model host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_drv(host_sda));

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // free cycle count for timing the watchdog
  always @(posedge core_clk) cyc <= cyc + 1;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    logic ok;
    host.write_reg(cmd, data, ok);
    check("write address ack", {7'h00, ok}, 8'h01);
  endtask
  task automatic expect_rd(input string what, input logic [7:0] cmd, input logic [7:0] exp);
    logic       ok;
    logic [7:0] d;
    host.read_reg(cmd, d, ok);
    check("read address ack", {7'h00, ok}, 8'h01);
    check(what, d, exp);
  endtask
  // bounded wait on the reset request; running out ends the run
  task automatic wait_soft_system_reset(input logic lvl, input int limit);
    int k;
    k = 0;
    while (system_reset !== lvl && k < limit)
    begin
      @(posedge core_clk);
      k++;
    end
    if (k >= limit)
    begin
      n_fail++;
      $display("mismatch system_reset expected %b seen timeout", lvl);
      end_of_test();
    end
  endtask
  // one-cycle pulse on the chosen fault inputs
  task automatic pulse(input logic [4:0] which);
    @(posedge core_clk);
    {fail_1v8, fail_1v35, fail_5v, fail_3v3, rail_12v_absent} <= which;
    @(posedge core_clk);
    {fail_1v8, fail_1v35, fail_5v, fail_3v3, rail_12v_absent} <= 5'h00;
  endtask

  initial
  begin
    {rst_b, fail_1v8, fail_1v35, fail_5v, fail_3v3, rail_12v_absent} = 6'h00;
    {n_fail, n_compared, t0} = '0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    // ordinary register traffic, write then read back
    for (int i = 0; i < 7; i++)
    begin
      wr(ROWS[i][31:24], ROWS[i][23:16]);
      expect_rd("table read", ROWS[i][15:8], ROWS[i][7:0]);
    end
    // fault flags, stickiness across system reset, then clear by write
    pulse(5'b10010);
    expect_rd("status a 1v8", CMD_STAT_A_RD, 8'h80);
    expect_rd("status b 3v3", CMD_STAT_B_RD, 8'h01);
    pulse(5'b01101);
    expect_rd("status a 1v35", CMD_STAT_A_RD, 8'h90);
    expect_rd("status b rails", CMD_STAT_B_RD, 8'h19);
    wr(CMD_CTRL_WR, 8'h01);
    wait_soft_system_reset(1'b1, 400);
    wait_soft_system_reset(1'b0, 400);
    expect_rd("status a kept", CMD_STAT_A_RD, 8'h90);
    expect_rd("status b kept", CMD_STAT_B_RD, 8'h19);
    expect_rd("control after reset", CMD_CTRL_RD, 8'h00);
    wr(CMD_STAT_A_WR, 8'h5A);
    expect_rd("status a cleared", CMD_STAT_A_RD, 8'h00);
    wr(CMD_STAT_B_WR, 8'h00);
    expect_rd("status b cleared", CMD_STAT_B_RD, 8'h00);
    // watchdog: every period, half mark and restart on the first one
    for (int s = 0; s < 4; s++)
    begin
      wr(CMD_CTRL_WR, {3'b000, 2'(s), 3'b100});
      t0 = cyc;
      if (s == 0)
      begin
        expect_rd("armed early", CMD_STAT_B_RD, 8'h80);
        repeat (1000) @(posedge core_clk);
        expect_rd("half elapsed", CMD_STAT_B_RD, 8'hA0);
        wr(CMD_CTRL_WR, 8'h00);
        t0 = cyc;
        expect_rd("after restart", CMD_STAT_B_RD, 8'h80);
      end
      wait_soft_system_reset(1'b1, 12000);
      check("expiry time", {7'h00, (cyc - t0 <= lim[s]) && (cyc - t0 >= lim[s] - 60)}, 8'h01);
      wait_soft_system_reset(1'b0, 400);
      expect_rd("watchdog cause", CMD_STAT_B_RD, 8'h40);
      expect_rd("control after expiry", CMD_CTRL_RD, 8'h00);
      wr(CMD_STAT_B_WR, 8'hFF);
    end
    // power-on reset mid-run clears flags and control
    wr(CMD_CTRL_WR, 8'hF8);
    pulse(5'b10000);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    expect_rd("status a after power-on", CMD_STAT_A_RD, 8'h00);
    expect_rd("control after power-on", CMD_CTRL_RD, CTRL_RESET);
    end_of_test();
  end
endmodule
`default_nettype wire
